// ---- hdl/imp_pkg.sv ----
// Package for the idle mode power control block.
// Assumes a single 250 MHz clock domain and a core that supplies bus values.
package imp_pkg;

  localparam int          CLK_MHZ      = 250;
  localparam int          PSC_W        = 8;
  localparam int          PSC_IDLE_BIT = 1;
  localparam logic [7:0]  PSC_RESET    = 8'h00;
  localparam logic [31:0] NMI_VEC_DEF  = 32'h0000_0010;
  // Resume takes one cycle: no oscillator settling is needed
  localparam int          WAKE_CYCLES  = 1;

  typedef enum logic [1:0] {
    IMP_OP_STORE,
    IMP_OP_SET,
    IMP_OP_CLR,
    IMP_OP_INV
  } imp_psc_op_t;

  typedef struct packed {
    logic [15:0] data;
    logic [23:0] addr;
    logic        rd_b;
    logic        we_b;
    logic        oe_b;
    logic        bus_cycle_start_strobe_b;
    logic        lwr_b;
    logic        uwr_b;
    logic        io_read_strobe_b;
    logic        io_write_strobe_b;
    logic [7:0]  cs_b;
    logic        bus_hold_acknowledge_b;
  } imp_bus_t;

  typedef struct packed {
    logic data;
    logic addr;
    logic ctl;
    logic bus_hold_acknowledge;
  } imp_bus_oe_t;

  typedef struct packed {
    logic [7:0] ras_b;
    logic       lcas_b;
    logic       upper_column_strobe_b;
    logic       refresh_request_output_b;
  } imp_dram_t;

  localparam imp_bus_t    BUS_RESET  = '{data: 16'h0000, addr: 24'h00_0000,
                                         cs_b: 8'hff, default: 1'b1};
  localparam imp_bus_oe_t OE_RESET   = '{default: 1'b0};
  localparam imp_dram_t   DRAM_RESET = '{ras_b: 8'hff, default: 1'b1};

endpackage : imp_pkg

// ---- hdl/imp_idle_ctrl.sv ----
// Idle mode power control: entry by power save register write, exit by
// the interrupt or reset pin, parking of the external expansion bus.
// Assumes all pins are synchronous to mclk and the core obeys the stop
// and clock enable outputs.
//
// Function
// RQ1: Oscillator runs, internal system clock gated off
// RQ2: Wake resumes at once, no stabilization wait
// RQ3: Store or bit instruction write enters idle
// RQ4: Execution stops, registers, RAM, ports retained
// RQ5: Peripherals halt, ports keep their held states
// RQ6: Byte, io strobes and chip selects high
// RQ7: Data, address, controls, hold acknowledge float
// RQ8: DRAM strobes run, hold/wait ignored, clock low
// RQ9: Only interrupt pin or reset pin exit
// RQ10: Interrupt pin wake also accepts the interrupt
// RQ11: Wake inside interrupt service leaves request pending
// RQ12: Wake service uses the single interrupt vector
// RQ13: Reset pin exit is a normal reset
`timescale 1ns/10ps
`default_nettype none

module imp_idle_ctrl #(
  parameter logic [31:0] NMI_VEC = imp_pkg::NMI_VEC_DEF
) (
  input  wire logic                 mclk,
  input  wire logic                 rst_b,
  input  wire logic                 psc_we,
  input  wire imp_pkg::imp_psc_op_t psc_op,
  input  wire logic [7:0]           psc_wdata,
  input  wire logic [2:0]           psc_bit,
  input  wire logic                 nmi_pin,
  input  wire logic                 reset_pin_b,
  input  wire logic                 in_nmi_srv,
  input  wire logic                 ext_mode,
  input  wire imp_pkg::imp_bus_t    core_bus,
  input  wire imp_pkg::imp_bus_oe_t core_oe,
  input  wire imp_pkg::imp_dram_t   core_dram,
  input  wire logic                 core_clock_output_pin,
  input  wire logic                 hold_req_pin,
  input  wire logic                 wait_pin,
  output logic                      osc_run,
  output logic                      sys_clk_en,
  output logic                      cpu_stop,
  output logic                      periph_stop,
  output logic                      port_hold,
  output logic                      idle_active,
  output logic                      sys_reset_req,
  output logic                      nmi_ack,
  output logic                      nmi_pend,
  output logic [31:0]               nmi_vector,
  output imp_pkg::imp_bus_t         bus_out,
  output imp_pkg::imp_bus_oe_t      bus_oe,
  output imp_pkg::imp_dram_t        dram_out,
  output logic                      hold_req_core,
  output logic                      wait_core,
  output logic                      clock_output_pin_pin
);
  import imp_pkg::*;

  typedef enum logic {
    IMP_RUN,
    IMP_IDLE
  } imp_state_t;

  imp_state_t       state_q;
  imp_state_t       state_d;
  logic [PSC_W-1:0] psc_q;
  logic [PSC_W-1:0] psc_d;
  logic [PSC_W-1:0] psc_new;
  logic             srv_q;
  logic             srv_d;
  logic             nmi_q;
  logic             nmi_rise;
  logic             ack_q;
  logic             ack_d;
  logic             pend_q;
  logic             pend_d;
  logic             rreq_q;
  logic             rreq_d;
  imp_bus_t         bus_q;
  imp_bus_t         bus_d;
  imp_bus_oe_t      oe_q;
  imp_bus_oe_t      oe_d;
  imp_dram_t        dram_q;
  logic             hreq_q;
  logic             hreq_d;
  logic             wait_q;
  logic             wait_d;
  logic             clko_q;
  logic             clko_d;
  logic             park;

  assign nmi_rise = nmi_pin & ~nmi_q;

  // Value the power save register takes for each instruction form
  always_comb begin
    psc_new = psc_q;
    unique case (psc_op)
      IMP_OP_STORE: psc_new = psc_wdata;
      IMP_OP_SET:   psc_new[psc_bit] = 1'b1;
      IMP_OP_CLR:   psc_new[psc_bit] = 1'b0;
      IMP_OP_INV:   psc_new[psc_bit] = ~psc_q[psc_bit];
    endcase
  end

  always_comb begin
    state_d = state_q;
    psc_d   = psc_q;
    srv_d   = srv_q;
    ack_d   = 1'b0;
    pend_d  = pend_q;
    rreq_d  = 1'b0;
    if (!reset_pin_b) begin
      // Same path as power-on: register and state return to reset values
      state_d = IMP_RUN; // RQ9
      psc_d   = PSC_RESET; // RQ13
      srv_d   = 1'b0;
      pend_d  = 1'b0;
      rreq_d  = 1'b1; // RQ13
    end else begin
      unique case (state_q)
        IMP_RUN: begin
          if (psc_we) begin
            psc_d = psc_new;
            if (psc_new[PSC_IDLE_BIT]) begin
              state_d = IMP_IDLE; // RQ3
              srv_d   = in_nmi_srv;
            end
          end
          // Ordinary interrupt path; a pending one is released once
          // the service routine has ended
          if (nmi_rise && in_nmi_srv) begin
            pend_d = 1'b1;
          end else if (nmi_rise || (pend_q && !in_nmi_srv)) begin
            ack_d  = 1'b1;
            pend_d = 1'b0;
          end
        end
        IMP_IDLE: begin
          if (nmi_rise) begin
            state_d             = IMP_RUN; // RQ9 RQ2
            psc_d[PSC_IDLE_BIT] = 1'b0;
            if (srv_q) begin
              pend_d = 1'b1; // RQ11
            end else begin
              ack_d = 1'b1; // RQ10
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= IMP_RUN;
      psc_q   <= PSC_RESET;
      srv_q   <= 1'b0;
      nmi_q   <= 1'b0;
      ack_q   <= 1'b0;
      pend_q  <= 1'b0;
      rreq_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      psc_q   <= psc_d;
      srv_q   <= srv_d;
      nmi_q   <= nmi_pin;
      ack_q   <= ack_d;
      pend_q  <= pend_d;
      rreq_q  <= rreq_d;
    end
  end

  // Clock generator never stops; only the system clock is gated
  assign osc_run       = 1'b1; // RQ1
  assign idle_active   = (state_q == IMP_IDLE);
  assign sys_clk_en    = ~idle_active; // RQ1
  assign cpu_stop      = idle_active; // RQ4
  assign periph_stop   = idle_active; // RQ5
  assign port_hold     = idle_active; // RQ4 RQ5
  assign sys_reset_req = rreq_q;
  assign nmi_ack       = ack_q;
  assign nmi_pend      = pend_q;
  // One handler address for every accepted interrupt
  assign nmi_vector    = NMI_VEC; // RQ12

  // Pins are parked from the cycle that idle is entered, so they are
  // registered from the next state rather than the current one
  assign park = (state_d == IMP_IDLE) && ext_mode;

  always_comb begin
    bus_d  = core_bus;
    oe_d   = core_oe;
    hreq_d = hold_req_pin;
    wait_d = wait_pin;
    clko_d = core_clock_output_pin;
    if (park) begin
      bus_d.lwr_b  = 1'b1; // RQ6
      bus_d.uwr_b  = 1'b1; // RQ6
      bus_d.io_read_strobe_b = 1'b1; // RQ6
      bus_d.io_write_strobe_b = 1'b1; // RQ6
      bus_d.cs_b   = 8'hff; // RQ6
      oe_d         = OE_RESET; // RQ7
    end
    if (state_d == IMP_IDLE) begin
      hreq_d = 1'b0; // RQ8
      wait_d = 1'b0; // RQ8
      clko_d = 1'b0; // RQ8
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      bus_q  <= BUS_RESET;
      oe_q   <= OE_RESET;
      dram_q <= DRAM_RESET;
      hreq_q <= 1'b0;
      wait_q <= 1'b0;
      clko_q <= 1'b0;
    end else begin
      bus_q  <= bus_d;
      oe_q   <= oe_d;
      dram_q <= core_dram; // RQ8
      hreq_q <= hreq_d;
      wait_q <= wait_d;
      clko_q <= clko_d;
    end
  end

  assign bus_out       = bus_q;
  assign bus_oe        = oe_q;
  assign dram_out      = dram_q;
  assign hold_req_core = hreq_q;
  assign wait_core     = wait_q;
  assign clock_output_pin_pin    = clko_q;

  a_idle_entry_store: assert property ( // RQ3
    @(posedge mclk) disable iff (!rst_b)
    (state_q == IMP_RUN && reset_pin_b && psc_we && psc_new[PSC_IDLE_BIT])
      |=> idle_active && !sys_clk_en && cpu_stop && osc_run
  ) else $error("idle not entered after register write");

  a_idle_only_pins: assert property ( // RQ9
    @(posedge mclk) disable iff (!rst_b)
    (idle_active && !nmi_rise && reset_pin_b) |=> idle_active
  ) else $error("idle left without interrupt or reset pin");

  a_wake_fast: assert property ( // RQ2
    @(posedge mclk) disable iff (!rst_b)
    (idle_active && nmi_rise && reset_pin_b)
      |=> !idle_active && sys_clk_en && !cpu_stop
  ) else $error("wake took more than one cycle");

  a_wake_accepts: assert property ( // RQ10
    @(posedge mclk) disable iff (!rst_b)
    (idle_active && nmi_rise && reset_pin_b && !srv_q)
      |=> nmi_ack && !nmi_pend ##1 !nmi_ack
  ) else $error("wake interrupt not accepted once");

  a_wake_pends: assert property ( // RQ11
    @(posedge mclk) disable iff (!rst_b)
    (idle_active && nmi_rise && reset_pin_b && srv_q)
      |=> nmi_pend && !nmi_ack
  ) else $error("wake inside service did not pend");

  a_park_strobes: assert property ( // RQ6
    @(posedge mclk) disable iff (!rst_b)
    $rose(idle_active) && $past(ext_mode)
      |-> bus_out.lwr_b && bus_out.uwr_b && bus_out.io_read_strobe_b
          && bus_out.io_write_strobe_b && (bus_out.cs_b == 8'hff)
  ) else $error("strobes not high on idle entry");

  a_park_float: assert property ( // RQ7
    @(posedge mclk) disable iff (!rst_b)
    (idle_active && $past(idle_active) && $past(ext_mode))
      |-> (bus_oe == OE_RESET)
  ) else $error("bus driven during idle");

  a_idle_clock_output_pin: assert property ( // RQ8
    @(posedge mclk) disable iff (!rst_b)
    idle_active |-> !clock_output_pin_pin && !hold_req_core && !wait_core
  ) else $error("clock or hold/wait active in idle");

  a_dram_runs: assert property ( // RQ8
    @(posedge mclk) disable iff (!rst_b)
    idle_active |-> (dram_out == $past(core_dram))
  ) else $error("dram strobes stopped in idle");

  a_reset_exit: assert property ( // RQ13
    @(posedge mclk) disable iff (!rst_b)
    !reset_pin_b |=> sys_reset_req && !idle_active && !nmi_pend
  ) else $error("reset pin did not act as reset");

  a_pend_release: assert property ( // RQ11
    @(posedge mclk) disable iff (!rst_b)
    (!idle_active && pend_q && !in_nmi_srv && !nmi_rise && reset_pin_b)
      |=> nmi_ack && !nmi_pend
  ) else $error("pending interrupt not released after service");

  a_clock_gating: assert property ( // RQ1 RQ5
    @(posedge mclk) disable iff (!rst_b)
    osc_run && (sys_clk_en != idle_active) && (periph_stop == idle_active)
  ) else $error("oscillator stopped or system clock not gated");

  a_vector_fixed: assert property ( // RQ12
    @(posedge mclk) disable iff (!rst_b)
    nmi_ack |-> (nmi_vector == NMI_VEC)
  ) else $error("interrupt accepted with another vector");

endmodule : imp_idle_ctrl

`default_nettype wire

// ---- sim/imp_far_side.sv ----
// Far-side model: interrupt pin, reset pin and the bus hold and wait pins.
// Assumes the bench calls pins() between edges; the pins change at the
// next falling edge of mclk, well clear of the sampling edge.
`timescale 1ns/10ps
`default_nettype none

module imp_far_side (
  input  wire logic mclk,
  output var logic  nmi_pin,
  output var logic  reset_pin_b,
  output var logic  hold_req_pin,
  output var logic  wait_pin
);

  initial begin
    nmi_pin      = 1'b0;
    reset_pin_b  = 1'b1;
    hold_req_pin = 1'b1;
    wait_pin     = 1'b1;
  end

  // Hold and wait stay asserted while idle, except during the pin noise, so that ignoring them shows
  task automatic pins(input logic nmi, input logic rst_v, input logic hold);
    @(negedge mclk);
    nmi_pin      = nmi;
    reset_pin_b  = rst_v;
    hold_req_pin = hold;
    wait_pin     = hold;
  endtask : pins

endmodule : imp_far_side
`default_nettype wire

// ---- sim/tb_imp_idle_ctrl.sv ----
// Bench for the idle mode power control block.
// Assumes the far-side model drives the pins; inputs change at negedge.
`timescale 1ns/10ps
`default_nettype none

module tb_imp_idle_ctrl;
  import imp_pkg::*;
  logic        mclk, rst_b, psc_we, in_nmi_srv, ext_mode, core_clock_output_pin;
  logic        nmi_pin, reset_pin_b, hold_req_pin, wait_pin, osc_run;
  logic        sys_clk_en, cpu_stop, periph_stop, port_hold, idle_active;
  logic        sys_reset_req, nmi_ack, nmi_pend, hold_req_core, wait_core;
  logic        clock_output_pin_pin;
  logic [7:0]  psc_wdata;
  logic [2:0]  psc_bit;
  logic [31:0] nmi_vector;
  imp_psc_op_t psc_op;
  imp_bus_t    core_bus, bus_out;
  imp_bus_oe_t core_oe, bus_oe;
  imp_dram_t   core_dram, dram_out;
  int          failures = 0;
  int          num_checks = 0;

  imp_far_side u_imp_far_side (.mclk, .nmi_pin, .reset_pin_b, .hold_req_pin, .wait_pin);
  imp_idle_ctrl u_imp_idle_ctrl (
    .mclk, .rst_b, .psc_we, .psc_op, .psc_wdata, .psc_bit, .nmi_pin, .reset_pin_b,
    .in_nmi_srv, .ext_mode, .core_bus, .core_oe, .core_dram, .core_clock_output_pin,
    .hold_req_pin, .wait_pin, .osc_run, .sys_clk_en, .cpu_stop, .periph_stop,
    .port_hold, .idle_active, .sys_reset_req, .nmi_ack, .nmi_pend, .nmi_vector,
    .bus_out, .bus_oe, .dram_out, .hold_req_core, .wait_core, .clock_output_pin_pin);

  always #2 mclk = ~mclk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc

  task automatic pins(input logic nmi, input logic rst_v);
    u_imp_far_side.pins(nmi, rst_v, 1'b1);
  endtask : pins

  // One-cycle write pulse, then a quiet edge so back-to-back calls never
  // lower and raise the strobe in one time step
  task automatic wr(input imp_psc_op_t op, input logic [7:0] d, input logic [2:0] b);
    psc_we = 1'b1;
    psc_op = op;
    psc_wdata = d;
    psc_bit = b;
    cyc(1);
    psc_we = 1'b0;
    cyc(1);
  endtask : wr

  task automatic chk_idle();
    chk(idle_active, 1'b1);
    chk({osc_run, sys_clk_en}, 2'b10);
    chk({cpu_stop, periph_stop, port_hold}, 3'b111);
    chk({bus_out.lwr_b, bus_out.uwr_b, bus_out.io_read_strobe_b, bus_out.io_write_strobe_b,
         bus_out.cs_b}, 12'hfff);
    chk(bus_oe, 4'h0);
    chk({dram_out, hold_req_core, wait_core, clock_output_pin_pin}, {core_dram, 3'h0});
  endtask : chk_idle

  task automatic nmi_wake();
    pins(1'b1, 1'b1);
    cyc(1);
    chk({idle_active, nmi_ack, nmi_pend, sys_clk_en}, 4'b0101);
    chk(nmi_vector, NMI_VEC_DEF);
    pins(1'b0, 1'b1);
    cyc(1);
    chk({nmi_ack, bus_oe}, {1'b0, core_oe});
    chk({hold_req_core, wait_core, clock_output_pin_pin}, 3'b111);
  endtask : nmi_wake

  task automatic t_noenter();
    wr(IMP_OP_CLR, 8'h00, 3'h1);
    wr(IMP_OP_STORE, 8'hfd, 3'h1);
    wr(IMP_OP_SET, 8'h00, 3'h0);
    cyc(1);
    chk(idle_active, 1'b0);
  endtask : t_noenter

  // Every entry opcode, then a refused write and pin noise that must not wake
  task automatic t_enter();
    imp_psc_op_t ops [3] = '{IMP_OP_STORE, IMP_OP_SET, IMP_OP_INV};
    for (int i = 0; i < 3; i++) begin
      wr(ops[i], 8'h02, 3'h1);
      chk_idle();
      wr(IMP_OP_CLR, 8'h00, 3'h1);
      core_dram.lcas_b = ~core_dram.lcas_b;
      u_imp_far_side.pins(1'b0, 1'b1, 1'b0);
      cyc(3);
      chk({idle_active, nmi_ack}, 2'b10);
      chk(dram_out, core_dram);
      pins(1'b0, 1'b1);
      cyc(1);
      nmi_wake();
    end
  endtask : t_enter

  task automatic t_pend();
    in_nmi_srv = 1'b1;
    ext_mode = 1'b0;
    wr(IMP_OP_SET, 8'h00, 3'h1);
    chk({idle_active, clock_output_pin_pin}, 2'b10);
    chk(bus_oe, core_oe);
    pins(1'b1, 1'b1);
    cyc(1);
    chk({idle_active, nmi_ack, nmi_pend}, 3'b001);
    pins(1'b0, 1'b1);
    in_nmi_srv = 1'b0;
    ext_mode = 1'b1;
    cyc(1);
    chk({nmi_ack, nmi_pend}, 2'b10);
    cyc(2);
    chk({nmi_ack, nmi_pend}, 2'b00);
  endtask : t_pend

  // Reset pin ends idle and clears the register, so INV sets the bit anew
  task automatic t_rstpin();
    wr(IMP_OP_SET, 8'h00, 3'h1);
    pins(1'b0, 1'b0);
    cyc(1);
    chk({sys_reset_req, idle_active, sys_clk_en}, 3'b101);
    pins(1'b0, 1'b1);
    cyc(3);
    chk({sys_reset_req, idle_active}, 2'b00);
    wr(IMP_OP_INV, 8'h00, 3'h1);
    chk(idle_active, 1'b1);
    nmi_wake();
  endtask : t_rstpin

  task automatic summarize();
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize

  initial begin
    #10000;
    failures++;
    summarize();
  end

  initial begin
    mclk = 1'b0;
    rst_b = 1'b0;
    psc_we = 1'b0;
    psc_op = IMP_OP_STORE;
    psc_wdata = 8'h00;
    psc_bit = 3'h0;
    in_nmi_srv = 1'b0;
    ext_mode = 1'b1;
    core_clock_output_pin = 1'b1;
    core_bus = '{data: 16'h5a5a, addr: 24'h12_3456, cs_b: 8'h00, default: 1'b0};
    core_oe = '{default: 1'b1};
    core_dram = '{ras_b: 8'h3c, default: 1'b0};
    cyc(16);
    chk({idle_active, sys_clk_en, nmi_ack, nmi_pend, clock_output_pin_pin}, 5'h08);
    chk({bus_oe, bus_out.cs_b}, 12'h0ff);
    rst_b = 1'b1;
    cyc(2);
    t_noenter();
    t_enter();
    t_pend();
    t_rstpin();
    summarize();
  end

endmodule : tb_imp_idle_ctrl
`default_nettype wire
